// ===== core/seq_ctrl_regs.vh
// constants for the equalizer control-pin front end
// assumes four-level pins arrive as 2-bit comparator codes
`ifndef SEQ_CTRL_REGS_VH
`define SEQ_CTRL_REGS_VH
`define SEQ_LVL_H 2'h3
`define SEQ_LVL_F 2'h2
`define SEQ_LVL_R 2'h1
`define SEQ_LVL_L 2'h0
`define SEQ_NSYNC 26
`define SEQ_SYNC_RST 26'h01ad555
`define SEQ_B_EN 0
`define SEQ_B_MODE 1
`define SEQ_B_BW 3
`define SEQ_B_INMUX 5
`define SEQ_B_OUTMUX 7
`define SEQ_B_VOD 9
`define SEQ_B_PATH 11
`define SEQ_B_CVOD 13
`define SEQ_B_LT 15
`define SEQ_B_PIN0 16
`define SEQ_B_PIN1 18
`define SEQ_B_SDA 20
`define SEQ_B_SCK 21
`define SEQ_B_LOCK 22
`define SEQ_B_CD 23
`define SEQ_B_CF 24
`define SEQ_B_INT 25
`define SEQ_LF_LOCK 2'h0
`define SEQ_LF_CD 2'h1
`define SEQ_LF_CF 2'h2
`define SEQ_LF_INT 2'h3
`define SEQ_PATH_RCLK 2'h0
`define SEQ_PATH_RCLK_CLK 2'h1
`define SEQ_PATH_BYPASS 2'h2
`define SEQ_SMB_BASE 3'h5
`define SEQ_STRAP_WAIT 2'h3
`define SEQ_SMB_BITS 4'h8
`endif

// ===== core/seq_ctrl_pins.v
// control-pin decode, serial port front end and lock pin for the cable equalizer
// assumes pins are asynchronous to CLK_I and register-side inputs are on CLK_I
// Behaviour
// - enable low puts the device into power-down
// - enable high runs normally; undriven enable reads high
// - mode select F picks SPI, L picks SMBus, changing shared pin roles
// - SPI access only while chip select is low; select idles high
// - SMBus mode latches two four-level straps at power-up, sixteen addresses
// - SPI drives readout line, samples write line, clock comes from host
// - SMBus data is open-drain both ways; clock driven by controller
// - lock pin pulled low when reclocker locked, released otherwise
// - lock pin can instead show carrier, cable fault or interrupt
// - data-path pin picks reclocked, reclocked with clock, or bypass; override
// - dual-input variant picks primary or redundant input; register override
// - fan-out enable pin sets both outputs' enables; register override
// - swing and emphasis pin shared by both fan-outs; register override
// - coax swing pin picks one of four amplitudes
// - loop-through enable input pulled high; driver off by default
// - bandwidth pin picks CDR loop bandwidth; override reaches more settings
// - cable fault on loop-through only with positive polarity in use
// - primary fan-out driver can be disabled by the user
// - four-level pins resolve to H, F, R, L; default reads F
`timescale 1ns/1ps
`include "seq_ctrl_regs.vh"
module seq_ctrl_pins #(
  parameter DUAL_INPUT = 1
) (
  input wire CLK_I,
  input wire SRST_I,
  input wire ENABLE_PIN_I,
  input wire [1:0] MODE_SELECT_LVL_I,
  input wire [1:0] CDR_BANDWIDTH_SELECT_LVL_I,
  input wire [1:0] INPUT_SOURCE_SELECT_LVL_I,
  input wire [1:0] FANOUT_ENABLE_SELECT_LVL_I,
  input wire [1:0] FANOUT_SWING_EMPHASIS_SELECT_LVL_I,
  input wire [1:0] DATA_PATH_SELECT_LVL_I,
  input wire [1:0] COAX_SWING_SELECT_LVL_I,
  input wire LOOPTHROUGH_ENABLE_PIN_I,
  input wire [1:0] SELECT_OR_STRAP_ZERO_PIN_I,
  input wire [1:0] READOUT_OR_STRAP_ONE_PIN_I,
  output reg READOUT_OR_STRAP_ONE_PIN_O,
  output reg READOUT_OR_STRAP_ONE_PIN_OE_O,
  input wire WRITE_IN_OR_BUS_DATA_PIN_I,
  output reg WRITE_IN_OR_BUS_DATA_PIN_O,
  output reg WRITE_IN_OR_BUS_DATA_PIN_OE_O,
  input wire SERIAL_CLOCK_PIN_I,
  input wire CDR_LOCK_I,
  input wire CARRIER_DETECT_I,
  input wire CABLE_FAULT_I,
  input wire EVENT_INT_I,
  output reg LOCK_PIN_O,
  output reg LOCK_PIN_OE_O,
  input wire [1:0] LOCK_FUNC_I,
  input wire BW_OVR_EN_I,
  input wire [2:0] BW_OVR_I,
  input wire IN_OVR_EN_I,
  input wire IN_OVR_I,
  input wire FANOUT_OVR_EN_I,
  input wire [1:0] FANOUT_OVR_I,
  input wire SWING_OVR_EN_I,
  input wire [1:0] SWING_OVR_I,
  input wire PATH_OVR_EN_I,
  input wire [1:0] PATH_OVR_I,
  input wire FANOUT_A_DISABLE_I,
  input wire LOOP_POS_POLARITY_I,
  input wire [7:0] SER_TX_BYTE_I,
  output reg POWER_DOWN_O,
  output reg SPI_MODE_O,
  output reg [2:0] CDR_BANDWIDTH_O,
  output reg INPUT_SOURCE_O,
  output reg FANOUT_A_EN_O,
  output reg FANOUT_B_EN_O,
  output reg [1:0] FANOUT_SWING_EMPHASIS_O,
  output reg [1:0] DATA_PATH_O,
  output reg [1:0] COAX_SWING_O,
  output reg LOOPTHROUGH_EN_O,
  output reg [6:0] SMB_ADDR_O,
  output reg [7:0] SER_RX_BYTE_O,
  output reg SER_RX_VALID_O
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_ACK = 2'h2;
  localparam ST_DATA = 2'h3;
  localparam [`SEQ_NSYNC-1:0] SYNC_RST = `SEQ_SYNC_RST;

  // override wins for as long as its enable is set
  function [1:0] pick2;
    input ovr_en;
    input [1:0] ovr;
    input [1:0] pin;
    begin
      pick2 = ovr_en ? ovr : pin;
    end
  endfunction

  wire [`SEQ_NSYNC-1:0] asy;
  assign asy = {EVENT_INT_I, CABLE_FAULT_I, CARRIER_DETECT_I, CDR_LOCK_I,
                SERIAL_CLOCK_PIN_I, WRITE_IN_OR_BUS_DATA_PIN_I,
                READOUT_OR_STRAP_ONE_PIN_I, SELECT_OR_STRAP_ZERO_PIN_I,
                LOOPTHROUGH_ENABLE_PIN_I, COAX_SWING_SELECT_LVL_I,
                DATA_PATH_SELECT_LVL_I, FANOUT_SWING_EMPHASIS_SELECT_LVL_I,
                FANOUT_ENABLE_SELECT_LVL_I, INPUT_SOURCE_SELECT_LVL_I,
                CDR_BANDWIDTH_SELECT_LVL_I, MODE_SELECT_LVL_I, ENABLE_PIN_I};

  reg [`SEQ_NSYNC-1:0] s1_ff;
  reg [`SEQ_NSYNC-1:0] s2_ff;
  reg [`SEQ_NSYNC-1:0] s3_ff;
  reg [`SEQ_NSYNC-1:0] flt_ff;
  reg [`SEQ_NSYNC-1:0] flt_d_ff;

  // reset values model pull-ups and mid-level defaults on the pins
  genvar gi;
  generate
    for (gi = 0; gi < `SEQ_NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge CLK_I) begin
        if (SRST_I) begin
          s1_ff[gi] <= SYNC_RST[gi];
          s2_ff[gi] <= SYNC_RST[gi];
          s3_ff[gi] <= SYNC_RST[gi];
          flt_ff[gi] <= SYNC_RST[gi];
          flt_d_ff[gi] <= SYNC_RST[gi];
        end else begin
          s1_ff[gi] <= asy[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          // a change counts only once stages two and three agree
          if (s2_ff[gi] == s3_ff[gi]) begin
            flt_ff[gi] <= s3_ff[gi];
          end
          flt_d_ff[gi] <= flt_ff[gi];
        end
      end
    end
  endgenerate

  wire en_lvl = flt_ff[`SEQ_B_EN];
  wire [1:0] mode_lvl = flt_ff[`SEQ_B_MODE+1:`SEQ_B_MODE];
  wire [1:0] bw_lvl = flt_ff[`SEQ_B_BW+1:`SEQ_B_BW];
  wire [1:0] inmux_lvl = flt_ff[`SEQ_B_INMUX+1:`SEQ_B_INMUX];
  wire [1:0] outmux_lvl = flt_ff[`SEQ_B_OUTMUX+1:`SEQ_B_OUTMUX];
  wire [1:0] vod_lvl = flt_ff[`SEQ_B_VOD+1:`SEQ_B_VOD];
  wire [1:0] path_lvl = flt_ff[`SEQ_B_PATH+1:`SEQ_B_PATH];
  wire [1:0] cvod_lvl = flt_ff[`SEQ_B_CVOD+1:`SEQ_B_CVOD];
  wire lt_pin = flt_ff[`SEQ_B_LT];
  wire [1:0] pin0_lvl = flt_ff[`SEQ_B_PIN0+1:`SEQ_B_PIN0];
  wire [1:0] pin1_lvl = flt_ff[`SEQ_B_PIN1+1:`SEQ_B_PIN1];
  wire sda = flt_ff[`SEQ_B_SDA];
  wire sda_d = flt_d_ff[`SEQ_B_SDA];
  wire sck = flt_ff[`SEQ_B_SCK];
  wire sck_d = flt_d_ff[`SEQ_B_SCK];

  // H and R have no documented serial role; treated as SPI
  wire smb_mode = (mode_lvl == `SEQ_LVL_L);
  wire spi_mode = ~smb_mode;
  wire cs_n = pin0_lvl[1];
  wire mosi = flt_ff[`SEQ_B_PIN1 + 2];
  wire sck_rise = sck & ~sck_d;
  wire sck_fall = ~sck & sck_d;
  wire smb_start = sck & sck_d & sda_d & ~sda;
  wire smb_stop = sck & sck_d & ~sda_d & sda;
  wire pdn = ~en_lvl;
  wire lt_on = ~lt_pin;

  reg [2:0] strap_cnt_ff;
  reg strap_done_ff;
  reg [2:0] spi_cnt_ff;
  reg [7:0] spi_rx_ff;
  reg [7:0] spi_tx_ff;
  reg [1:0] smb_st_ff;
  reg [3:0] smb_cnt_ff;
  reg [7:0] smb_sh_ff;
  reg smb_drv_ff;
  reg lock_ind;
  reg [1:0] fan_sel;

  // straps caught once after the synchronisers have settled
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      strap_cnt_ff <= 3'h0;
      strap_done_ff <= 1'b0;
      SMB_ADDR_O <= 7'h00;
    end else if (!strap_done_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 3'h1;
      // one edge past the wait: filter output first shows the strap on that edge
      if (strap_cnt_ff == {1'b0, `SEQ_STRAP_WAIT} + 3'h1) begin
        strap_done_ff <= 1'b1;
        SMB_ADDR_O <= {`SEQ_SMB_BASE, pin1_lvl, pin0_lvl};
      end
    end
  end

  // serial front end: SPI shifter and SMBus write target
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      spi_cnt_ff <= 3'h0;
      spi_rx_ff <= 8'h00;
      spi_tx_ff <= 8'h00;
      smb_st_ff <= ST_IDLE;
      smb_cnt_ff <= 4'h0;
      smb_sh_ff <= 8'h00;
      smb_drv_ff <= 1'b0;
      SER_RX_BYTE_O <= 8'h00;
      SER_RX_VALID_O <= 1'b0;
    end else begin
      SER_RX_VALID_O <= 1'b0;
      if (!spi_mode || cs_n) begin
        spi_cnt_ff <= 3'h0;
        spi_tx_ff <= SER_TX_BYTE_I;
      end else begin
        if (sck_rise) begin
          spi_rx_ff <= {spi_rx_ff[6:0], mosi};
          spi_cnt_ff <= spi_cnt_ff + 3'h1;
          if (spi_cnt_ff == 3'h7) begin
            SER_RX_BYTE_O <= {spi_rx_ff[6:0], mosi};
            SER_RX_VALID_O <= 1'b1;
          end
        end
        if (sck_fall) begin
          // count wrapped to zero: next byte goes out msb first
          if (spi_cnt_ff == 3'h0) begin
            spi_tx_ff <= SER_TX_BYTE_I;
          end else begin
            spi_tx_ff <= {spi_tx_ff[6:0], 1'b0};
          end
        end
      end
      if (!smb_mode || smb_stop) begin
        smb_st_ff <= ST_IDLE;
        smb_drv_ff <= 1'b0;
      end else if (smb_start) begin
        smb_st_ff <= ST_ADDR;
        smb_cnt_ff <= 4'h0;
        smb_drv_ff <= 1'b0;
      end else begin
        case (smb_st_ff)
          ST_ADDR, ST_DATA: begin
            if (sck_rise) begin
              smb_sh_ff <= {smb_sh_ff[6:0], sda};
              smb_cnt_ff <= smb_cnt_ff + 4'h1;
            end
            if (sck_fall && smb_cnt_ff == `SEQ_SMB_BITS) begin
              smb_cnt_ff <= 4'h0;
              if (smb_st_ff == ST_DATA) begin
                SER_RX_BYTE_O <= smb_sh_ff;
                SER_RX_VALID_O <= 1'b1;
                smb_drv_ff <= 1'b1;
                smb_st_ff <= ST_ACK;
              end else if (smb_sh_ff[7:1] == SMB_ADDR_O && !smb_sh_ff[0]) begin
                smb_drv_ff <= 1'b1;
                smb_st_ff <= ST_ACK;
              end else begin
                // other address or read: stay off the bus until next start
                smb_st_ff <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (sck_fall) begin
              smb_drv_ff <= 1'b0;
              smb_st_ff <= ST_DATA;
            end
          end
          default: begin
            smb_drv_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  always @* begin
    case (LOCK_FUNC_I)
      `SEQ_LF_LOCK: lock_ind = flt_ff[`SEQ_B_LOCK];
      `SEQ_LF_CD: lock_ind = flt_ff[`SEQ_B_CD];
      `SEQ_LF_CF: lock_ind = flt_ff[`SEQ_B_CF] & LOOP_POS_POLARITY_I & lt_on;
      default: lock_ind = flt_ff[`SEQ_B_INT];
    endcase
  end

  // fan-out enables as {b, a}
  always @* begin
    case (outmux_lvl)
      `SEQ_LVL_H: fan_sel = 2'h3;
      `SEQ_LVL_F: fan_sel = 2'h1;
      `SEQ_LVL_R: fan_sel = 2'h2;
      default: fan_sel = 2'h0;
    endcase
  end

  wire [1:0] fan_eff;
  assign fan_eff = pick2(FANOUT_OVR_EN_I, FANOUT_OVR_I, fan_sel);

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      POWER_DOWN_O <= 1'b0;
      SPI_MODE_O <= 1'b1;
      CDR_BANDWIDTH_O <= {1'b0, `SEQ_LVL_F};
      INPUT_SOURCE_O <= 1'b0;
      FANOUT_A_EN_O <= 1'b0;
      FANOUT_B_EN_O <= 1'b0;
      FANOUT_SWING_EMPHASIS_O <= `SEQ_LVL_F;
      DATA_PATH_O <= `SEQ_PATH_RCLK;
      COAX_SWING_O <= `SEQ_LVL_F;
      LOOPTHROUGH_EN_O <= 1'b0;
      LOCK_PIN_O <= 1'b0;
      LOCK_PIN_OE_O <= 1'b0;
      READOUT_OR_STRAP_ONE_PIN_O <= 1'b0;
      READOUT_OR_STRAP_ONE_PIN_OE_O <= 1'b0;
      WRITE_IN_OR_BUS_DATA_PIN_O <= 1'b0;
      WRITE_IN_OR_BUS_DATA_PIN_OE_O <= 1'b0;
    end else begin
      POWER_DOWN_O <= pdn;
      SPI_MODE_O <= spi_mode;
      if (BW_OVR_EN_I) begin
        CDR_BANDWIDTH_O <= BW_OVR_I;
      end else begin
        CDR_BANDWIDTH_O <= {1'b0, bw_lvl};
      end
      if (DUAL_INPUT == 0) begin
        INPUT_SOURCE_O <= 1'b0;
      end else if (IN_OVR_EN_I) begin
        INPUT_SOURCE_O <= IN_OVR_I;
      end else begin
        INPUT_SOURCE_O <= ~inmux_lvl[1];
      end
      FANOUT_A_EN_O <= ~pdn & ~FANOUT_A_DISABLE_I & fan_eff[0];
      FANOUT_B_EN_O <= ~pdn & fan_eff[1];
      FANOUT_SWING_EMPHASIS_O <= pick2(SWING_OVR_EN_I, SWING_OVR_I, vod_lvl);
      case (path_lvl)
        `SEQ_LVL_H, `SEQ_LVL_F: DATA_PATH_O <= pick2(PATH_OVR_EN_I, PATH_OVR_I, `SEQ_PATH_RCLK);
        `SEQ_LVL_R: DATA_PATH_O <= pick2(PATH_OVR_EN_I, PATH_OVR_I, `SEQ_PATH_RCLK_CLK);
        default: DATA_PATH_O <= pick2(PATH_OVR_EN_I, PATH_OVR_I, `SEQ_PATH_BYPASS);
      endcase
      COAX_SWING_O <= cvod_lvl;
      LOOPTHROUGH_EN_O <= lt_on & ~pdn;
      LOCK_PIN_O <= 1'b0;
      LOCK_PIN_OE_O <= lock_ind & ~pdn;
      READOUT_OR_STRAP_ONE_PIN_O <= spi_tx_ff[7];
      READOUT_OR_STRAP_ONE_PIN_OE_O <= spi_mode & ~cs_n;
      WRITE_IN_OR_BUS_DATA_PIN_O <= 1'b0;
      WRITE_IN_OR_BUS_DATA_PIN_OE_O <= smb_mode & smb_drv_ff;
    end
  end

endmodule // seq_ctrl_pins

// ===== test/seq_ctrl_pins_chk.sv
// port checker for seq_ctrl_pins, bound below
// assumes one clock domain with synchronous reset
`timescale 1ns/1ps
module seq_ctrl_pins_chk (
  input wire CLK_I,
  input wire SRST_I,
  input wire BW_OVR_EN_I,
  input wire [2:0] BW_OVR_I,
  input wire PATH_OVR_EN_I,
  input wire [1:0] PATH_OVR_I,
  input wire FANOUT_A_DISABLE_I,
  input wire FANOUT_A_EN_O,
  input wire LOOPTHROUGH_EN_O,
  input wire POWER_DOWN_O,
  input wire SPI_MODE_O,
  input wire READOUT_OR_STRAP_ONE_PIN_OE_O,
  input wire WRITE_IN_OR_BUS_DATA_PIN_OE_O,
  input wire SER_RX_VALID_O,
  input wire [2:0] CDR_BANDWIDTH_O,
  input wire [1:0] DATA_PATH_O,
  input wire [6:0] SMB_ADDR_O
);
  // outputs hold reset values for a few edges, so wait before judging
  logic [2:0] age_ff;
  wire ripe = (age_ff == 3'h7);
  always @(posedge CLK_I) begin
    age_ff <= SRST_I ? 3'h0 : (ripe ? age_ff : age_ff + 3'h1);
  end
  default clocking ck @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  bw_override_a: assert property (ripe && BW_OVR_EN_I |=> CDR_BANDWIDTH_O == $past(BW_OVR_I))
    else $error("bandwidth override ignored");
  path_override_a: assert property (ripe && PATH_OVR_EN_I |=> DATA_PATH_O == $past(PATH_OVR_I))
    else $error("data path override ignored");
  fanout_a_off_a: assert property (ripe && FANOUT_A_DISABLE_I |=> !FANOUT_A_EN_O)
    else $error("fan-out a still on");
  down_quiet_a: assert property (POWER_DOWN_O && $past(POWER_DOWN_O) |-> !FANOUT_A_EN_O && !LOOPTHROUGH_EN_O)
    else $error("driver on in power down");
  sda_spi_a: assert property (SPI_MODE_O |-> !WRITE_IN_OR_BUS_DATA_PIN_OE_O)
    else $error("data pin pulled in spi mode");
  readout_smb_a: assert property (!SPI_MODE_O |-> !READOUT_OR_STRAP_ONE_PIN_OE_O)
    else $error("readout driven in smbus mode");
  rx_pulse_a: assert property (SER_RX_VALID_O |=> !SER_RX_VALID_O)
    else $error("byte strobe longer than a cycle");
  addr_hold_a: assert property (ripe |-> $stable(SMB_ADDR_O))
    else $error("address moved after power-up");
  cover property (SER_RX_VALID_O && !SPI_MODE_O);
  cover property (WRITE_IN_OR_BUS_DATA_PIN_OE_O);
  cover property (ripe && PATH_OVR_EN_I);
endmodule // seq_ctrl_pins_chk
bind seq_ctrl_pins seq_ctrl_pins_chk i_seq_ctrl_pins_chk (.*);

// ===== test/seq_host_model.sv
// host controller model for the serial port, spi or smbus
// assumes 25 MHz bench clock; link half period is four cycles
`timescale 1ns/1ps
module seq_host_model (
  input wire clk_i,
  input wire smb_i,
  input wire [1:0] strap0_i,
  input wire rdo_i,
  input wire rdo_oe_i,
  input wire sda_oe_i,
  output wire [1:0] sel_pin_o,
  output wire data_pin_o,
  output logic sck_o
);
  logic cs_ff = 1'b1;
  logic dq_ff = 1'b1;
  // released readout shows no stale bit
  wire miso = rdo_oe_i ? rdo_i : ~rdo_i;
  assign sel_pin_o = smb_i ? strap0_i : {cs_ff, 1'b0};
  assign data_pin_o = dq_ff & ~sda_oe_i;
  initial sck_o = 1'b0;
  task automatic hp();
    repeat (4) @(negedge clk_i);
  endtask
  task automatic spi(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
    cs_ff = ~sel;
    repeat (8) @(negedge clk_i);
    for (int i = 7; i >= 0; i--) begin
      dq_ff = tx[i];
      hp();
      sck_o = 1'b1;
      hp();
      rx[i] = miso; // late sample: readout moves well after the fall
      sck_o = 1'b0;
    end
    hp();
    cs_ff = 1'b1;
  endtask
  task automatic sbit(input logic b, output logic r);
    repeat (2) @(negedge clk_i);
    dq_ff = b;
    hp();
    sck_o = 1'b1;
    hp();
    r = data_pin_o;
    sck_o = 1'b0;
  endtask
  task automatic smb(input logic [15:0] ad, output logic [1:0] ack);
    logic r;
    sck_o = 1'b1;
    hp();
    dq_ff = 1'b0;
    hp();
    sck_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sbit(ad[i], r);
      if (i % 8 == 0) begin
        sbit(1'b1, r);
        ack[i / 8] = ~r;
      end
    end
    sbit(1'b0, r);
    sck_o = 1'b1;
    hp();
    dq_ff = 1'b1;
  endtask
endmodule // seq_host_model

// ===== test/seq_ctrl_pins_tb.sv
// self-checking bench for seq_ctrl_pins
// assumes seq_host_model drives select, data and clock pins
`timescale 1ns/1ps
module seq_ctrl_pins_tb;
  logic CLK_I = 0, SRST_I = 1, ENABLE_PIN_I = 1, LOOPTHROUGH_ENABLE_PIN_I = 1, CDR_LOCK_I = 0, CARRIER_DETECT_I = 0;
  logic CABLE_FAULT_I = 0, EVENT_INT_I = 0, BW_OVR_EN_I = 0, IN_OVR_EN_I = 0, FANOUT_OVR_EN_I = 0, SWING_OVR_EN_I = 0;
  logic PATH_OVR_EN_I = 0, IN_OVR_I = 0, FANOUT_A_DISABLE_I = 0, LOOP_POS_POLARITY_I = 1;
  logic [1:0] MODE_SELECT_LVL_I = 2, CDR_BANDWIDTH_SELECT_LVL_I = 2, INPUT_SOURCE_SELECT_LVL_I = 2, strap0 = 2;
  logic [1:0] FANOUT_ENABLE_SELECT_LVL_I = 2, FANOUT_SWING_EMPHASIS_SELECT_LVL_I = 2, DATA_PATH_SELECT_LVL_I = 2;
  logic [1:0] COAX_SWING_SELECT_LVL_I = 2, READOUT_OR_STRAP_ONE_PIN_I = 2, LOCK_FUNC_I = 0, ack;
  logic [1:0] FANOUT_OVR_I = 0, SWING_OVR_I = 0, PATH_OVR_I = 0;
  logic [2:0] BW_OVR_I = 0;
  logic [7:0] SER_TX_BYTE_I = 8'ha5, rx;
  wire [1:0] SELECT_OR_STRAP_ZERO_PIN_I, FANOUT_SWING_EMPHASIS_O, DATA_PATH_O, COAX_SWING_O;
  wire WRITE_IN_OR_BUS_DATA_PIN_I, SERIAL_CLOCK_PIN_I, READOUT_OR_STRAP_ONE_PIN_O, READOUT_OR_STRAP_ONE_PIN_OE_O;
  wire WRITE_IN_OR_BUS_DATA_PIN_O, WRITE_IN_OR_BUS_DATA_PIN_OE_O, LOCK_PIN_O, LOCK_PIN_OE_O, POWER_DOWN_O;
  wire SPI_MODE_O, INPUT_SOURCE_O, FANOUT_A_EN_O, FANOUT_B_EN_O, LOOPTHROUGH_EN_O, SER_RX_VALID_O;
  wire [2:0] CDR_BANDWIDTH_O;
  wire [6:0] SMB_ADDR_O;
  wire [7:0] SER_RX_BYTE_O;
  int err_total = 0, n_checks = 0, vcnt = 0;
  // row: level, {b,a} fan-out, data path, input source
  logic [6:0] rows [4] = '{7'h78, 7'h48, 7'h33, 7'h05};
  seq_ctrl_pins #(.DUAL_INPUT(1)) i_seq_ctrl_pins (.*);
  seq_host_model i_seq_host_model (.clk_i(CLK_I), .smb_i(MODE_SELECT_LVL_I == 2'h0), .strap0_i(strap0),
    .rdo_i(READOUT_OR_STRAP_ONE_PIN_O), .rdo_oe_i(READOUT_OR_STRAP_ONE_PIN_OE_O),
    .sda_oe_i(WRITE_IN_OR_BUS_DATA_PIN_OE_O), .sel_pin_o(SELECT_OR_STRAP_ZERO_PIN_I),
    .data_pin_o(WRITE_IN_OR_BUS_DATA_PIN_I), .sck_o(SERIAL_CLOCK_PIN_I));
  always #20 CLK_I = ~CLK_I;
  always @(posedge CLK_I) begin
    vcnt <= vcnt + (SER_RX_VALID_O === 1'b1);
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge CLK_I);
  endtask
  task automatic rst(input logic [1:0] mode);
    MODE_SELECT_LVL_I = mode;
    SRST_I = 1;
    wt(10);
    chk({SPI_MODE_O, CDR_BANDWIDTH_O, POWER_DOWN_O}, 8'h14);
    SRST_I = 0;
    wt(8);
  endtask
  task automatic give_verdict();
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    wt(20000);
    err_total++;
    give_verdict();
  end
  initial begin
    rst(2'h2);
    foreach (rows[r]) begin
      {CDR_BANDWIDTH_SELECT_LVL_I, INPUT_SOURCE_SELECT_LVL_I, FANOUT_ENABLE_SELECT_LVL_I} = {3{rows[r][6:5]}};
      {FANOUT_SWING_EMPHASIS_SELECT_LVL_I, DATA_PATH_SELECT_LVL_I, COAX_SWING_SELECT_LVL_I} = {3{rows[r][6:5]}};
      wt(6);
      chk({FANOUT_B_EN_O, FANOUT_A_EN_O, DATA_PATH_O, INPUT_SOURCE_O}, rows[r][4:0]);
      chk({FANOUT_SWING_EMPHASIS_O, COAX_SWING_O, CDR_BANDWIDTH_O}, {rows[r][6:5], rows[r][6:5], 1'b0, rows[r][6:5]});
      {BW_OVR_EN_I, IN_OVR_EN_I, FANOUT_OVR_EN_I, SWING_OVR_EN_I, PATH_OVR_EN_I} = 5'h1f;
      {BW_OVR_I, IN_OVR_I, FANOUT_OVR_I, SWING_OVR_I} = {1'b1, rows[r][6:5], rows[r][5], rows[r][6:5], ~rows[r][6:5]};
      PATH_OVR_I = 2'(r % 3);
      wt(2);
      chk({FANOUT_B_EN_O, FANOUT_A_EN_O, INPUT_SOURCE_O, CDR_BANDWIDTH_O}, {rows[r][6:5], rows[r][5], 1'b1, rows[r][6:5]});
      chk({FANOUT_SWING_EMPHASIS_O, DATA_PATH_O}, {~rows[r][6:5], 2'(r % 3)});
      {BW_OVR_EN_I, IN_OVR_EN_I, FANOUT_OVR_EN_I, SWING_OVR_EN_I, PATH_OVR_EN_I} = 5'h00;
    end
    wt(2);
    chk(DATA_PATH_O, 2'h2);
    LOOPTHROUGH_ENABLE_PIN_I = 0;
    for (int k = 0; k < 8; k++) begin
      {CARRIER_DETECT_I, CABLE_FAULT_I, EVENT_INT_I, CDR_LOCK_I} = {{3{k[2]}}, ~k[2]};
      LOCK_FUNC_I = k[1:0];
      wt(6);
      chk({LOCK_PIN_O, LOCK_PIN_OE_O}, (k[1:0] == 0) ^ k[2]);
    end
    chk(LOOPTHROUGH_EN_O, 1);
    {LOOP_POS_POLARITY_I, LOCK_FUNC_I, FANOUT_ENABLE_SELECT_LVL_I, FANOUT_A_DISABLE_I} = 6'h17;
    wt(6);
    chk({LOCK_PIN_OE_O, FANOUT_B_EN_O, FANOUT_A_EN_O}, 3'h2);
    ENABLE_PIN_I = 0;
    wt(6);
    chk({POWER_DOWN_O, FANOUT_B_EN_O, LOOPTHROUGH_EN_O}, 3'h4);
    ENABLE_PIN_I = 1;
    wt(6);
    chk({POWER_DOWN_O, FANOUT_B_EN_O, LOOPTHROUGH_EN_O}, 3'h3);
    i_seq_host_model.spi(8'h3c, 1, rx);
    wt(6);
    chk(rx, 8'ha5);
    chk(SER_RX_BYTE_O ^ 8'(vcnt), 8'h3d);
    i_seq_host_model.spi(8'hc3, 0, rx);
    wt(6);
    chk(SER_RX_BYTE_O ^ 8'(vcnt), 8'h3d);
    {strap0, READOUT_OR_STRAP_ONE_PIN_I} = 4'h7;
    rst(2'h0);
    chk({SPI_MODE_O, SMB_ADDR_O}, 8'h5d);
    i_seq_host_model.smb(16'hba96, ack);
    wt(6);
    chk({ack, SER_RX_BYTE_O}, 10'h396);
    i_seq_host_model.smb(16'hb869, ack);
    chk(ack, 0);
    i_seq_host_model.smb(16'hbb69, ack);
    wt(6);
    chk({ack, 8'(vcnt)}, 2);
    give_verdict();
  end
endmodule // seq_ctrl_pins_tb
